// >>> burst_monitor.sv
// port checker of the synchronous burst interface
`timescale 1ns/100ps
`default_nettype none
`include "psram_burst_defs.svh"
module burst_monitor (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // burst bus
   input wire logic mem_clk,
   input wire logic chip_enable_n,
   input wire logic addr_latch_n,
   input wire logic config_reg_select,
   input wire logic dq_oe_n,
   input wire logic wait_out,
   // array and register sides
   input wire logic array_wr,
   input wire logic array_rd,
   input wire logic [`REG_ADDR_W-1:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata
);
   logic [15:0] cfg;
   logic sync_on;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // shadow of the configuration register
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) cfg <= `BUS_CONFIG_RESET;
      else if (reg_wr && reg_addr == `BUS_CONFIG_OFS) cfg <= reg_wdata;
   end
   assign sync_on = !cfg[`SYNC_MODE_BIT];
   // qualified start edge, quiet bus
   sequence start_s;
      $rose(mem_clk) && !chip_enable_n && !addr_latch_n && !config_reg_select && sync_on;
   endsequence
   sequence quiet_s;
      dq_oe_n && !wait_out;
   endsequence
   cfg_readback_a: assert property (reg_rd && reg_addr == `BUS_CONFIG_OFS |=> reg_rdata == $past(cfg))
      else $error("config readback wrong");
   unmapped_zero_a: assert property (reg_rd && reg_addr[3] |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   wait_start_a: assert property (start_s |-> ##[1:8] wait_out)
      else $error("wait missing at burst start");
   async_quiet_a: assert property (!sync_on |-> !wait_out && !array_rd && dq_oe_n)
      else $error("burst activity in async mode");
   async_idle_a: assert property (reg_rd && reg_addr == `STATUS_OFS && !sync_on |=> reg_rdata[9:8] == 2'h0)
      else $error("state not idle in async mode");
   ce_float_a: assert property ($rose(chip_enable_n) |-> ##[1:6] quiet_s)
      else $error("bus not released after chip enable");
   strobe_excl_a: assert property (!(array_wr && array_rd))
      else $error("array read and write together");
   wr_pulse_a: assert property (array_wr |=> !array_wr)
      else $error("array write longer than one cycle");
endmodule
bind psram_sync_burst_interface burst_monitor mon_u (.core_clk, .resetn, .mem_clk, .chip_enable_n,
   .addr_latch_n, .config_reg_select, .dq_oe_n, .wait_out, .array_wr, .array_rd, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
`default_nettype wire

// >>> mem_ctl_model.sv
// behavioural memory controller on the burst bus
`timescale 1ns/100ps
`default_nettype none
`include "psram_burst_defs.svh"
module mem_ctl_model (
   // clock
   input wire logic core_clk,
   // burst bus
   output logic mem_clk,
   output logic chip_enable_n,
   output logic addr_latch_n,
   output logic output_enable_n,
   output logic write_enable_n,
   output logic lower_byte_enable_n,
   output logic upper_byte_enable_n,
   output logic config_reg_select,
   output logic [`PIN_ADDR_W-1:0] addr,
   output logic [`PIN_DATA_W-1:0] dq_in,
   input wire logic wait_out
);
   // idle bus, link clock stands low
   initial begin
      {mem_clk, chip_enable_n, addr_latch_n, output_enable_n, write_enable_n} = 5'h0f;
      {lower_byte_enable_n, upper_byte_enable_n, config_reg_select} = 3'h6;
      addr = 23'h00_0000;
      dq_in = 16'h0000;
   end
   // one link period; released lines toggle
   task automatic tick(input bit drv);
      mem_clk <= 1'b1;
      repeat (4) @(posedge core_clk);
      mem_clk <= 1'b0;
      addr_latch_n <= 1'b1;
      addr <= ~addr;
      if (!drv) dq_in <= ~dq_in;
      repeat (4) @(posedge core_clk);
   endtask
   // start edge, latency, then n data edges
   task automatic burst(input logic [22:0] a, input bit wr, input logic [1:0] be, input logic [15:0] d,
         input int n, input bit keep, output int lat);
      chip_enable_n <= 1'b0;
      addr_latch_n <= 1'b0;
      addr <= a;
      write_enable_n <= !wr;
      output_enable_n <= wr;
      {upper_byte_enable_n, lower_byte_enable_n} <= be;
      if (wr) dq_in <= d;
      repeat (4) @(posedge core_clk);
      tick(wr);
      lat = 0;
      while (wait_out === 1'b1 && lat < 40) begin
         tick(wr);
         lat++;
      end
      for (int i = 0; i < n && wait_out !== 1'b1; i++) tick(wr);
      if (!keep) chip_enable_n <= 1'b1;
      repeat (8) @(posedge core_clk);
   endtask
   // unclocked word write, write enable rises first
   task automatic async_wr(input logic [22:0] a, input logic [15:0] d);
      addr <= a;
      dq_in <= d;
      repeat (2) @(posedge core_clk);
      {chip_enable_n, write_enable_n, lower_byte_enable_n, upper_byte_enable_n} <= 4'h0;
      repeat (6) @(posedge core_clk);
      write_enable_n <= 1'b1;
      repeat (6) @(posedge core_clk);
      {chip_enable_n, lower_byte_enable_n, upper_byte_enable_n} <= 3'h7;
      dq_in <= ~d;
      repeat (6) @(posedge core_clk);
   endtask
endmodule
`default_nettype wire

// >>> psram_burst_defs.svh
// constants of the synchronous burst interface
`ifndef PSRAM_BURST_DEFS_SVH
`define PSRAM_BURST_DEFS_SVH

// pin bundle widths
`define PIN_ADDR_W 23
`define PIN_DATA_W 16

// register bus map, byte addresses
`define REG_ADDR_W 4
`define BUS_CONFIG_OFS 4'h0
`define STATUS_OFS 4'h4

// bus_config_reg fields and reset value
`define SYNC_MODE_BIT 15
`define LAT_TYPE_BIT 14
`define LAT_COUNT_HI 13
`define LAT_COUNT_LO 11
`define WAIT_TIMING_BIT 8
`define BURST_LEN_HI 2
`define BURST_LEN_LO 0
`define BUS_CONFIG_RESET 16'h9907

// burst length codes
`define BLEN_4 3'h1
`define BLEN_8 3'h2
`define BLEN_16 3'h3
`define BLEN_32 3'h4
`define BLEN_CONT 3'h7

// counts
`define WORDS_4 6'h04
`define WORDS_8 6'h08
`define WORDS_16 6'h10
`define WORDS_32 6'h20
`define WORDS_NONE 6'h00
`define REFRESH_EXTRA 4'h3
`define ROW_WORDS 128
`define LAT_ONE 4'h1
`define LAT_TWO 4'h2

`endif

// >>> psram_burst_pkg.sv
// types shared by the synchronous burst interface
`include "psram_burst_defs.svh"
package psram_burst_pkg;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LATENCY = 2'b01,
      ST_XFER = 2'b10,
      ST_ROW_END = 2'b11
   } burst_state_t;

   typedef struct packed {
      logic clk;
      logic ce_n;
      logic adv_n;
      logic oe_n;
      logic we_n;
      logic lb_n;
      logic ub_n;
      logic cr;
      logic [`PIN_ADDR_W-1:0] addr;
      logic [`PIN_DATA_W-1:0] dq;
   } pins_t;

endpackage

// >>> psram_sync_burst_interface.sv
// device side of the synchronous burst interface of a pseudo-static RAM
`timescale 1ns/100ps
`default_nettype none
`include "psram_burst_defs.svh"

// usage limits of this interface
// - the link clock is sampled, not used as a clock: each of its levels
//   must last at least two core clocks or edges are lost
// - pins reach the logic two core clocks after they change
// - chip enable high ends a burst at once and floats the data pins
// - a configuration access (select high) never starts a burst
// - the array must answer a read strobe in the following core clock
// - refresh_pending is sampled once, at the latch edge of a read burst
// - a continuous burst runs until a row end, chip enable high or a new latch edge
// - at a row end WAIT stays high until chip enable goes high
// - an access that saw a link clock rise is never also an unclocked write
// - unclocked writes need both byte enables low and are always full words
// - the configuration register is written only from the register port
// - status reads show state, mode, direction and words moved
// - wait timing bit one drops WAIT one link clock before the data edge
// - writes always use the programmed latency, refresh or not

module psram_sync_burst_interface #(
   parameter int ROW_WORDS = `ROW_WORDS
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // burst bus from the memory controller
   input wire logic mem_clk,
   input wire logic chip_enable_n,
   input wire logic addr_latch_n,
   input wire logic output_enable_n,
   input wire logic write_enable_n,
   input wire logic lower_byte_enable_n,
   input wire logic upper_byte_enable_n,
   input wire logic config_reg_select,
   input wire logic [`PIN_ADDR_W-1:0] addr,
   input wire logic [`PIN_DATA_W-1:0] dq_in,
   output logic [`PIN_DATA_W-1:0] dq_out,
   output logic dq_oe_n,
   output logic wait_out,
   // memory array side
   output logic array_wr,
   output logic array_rd,
   output logic [`PIN_ADDR_W-1:0] array_addr,
   output logic [`PIN_DATA_W-1:0] array_wdata,
   output logic [1:0] array_be_n,
   input wire logic [`PIN_DATA_W-1:0] array_rdata,
   input wire logic refresh_pending,
   // register port
   input wire logic [`REG_ADDR_W-1:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata
);

   typedef struct packed {
      // pin pipeline
      psram_burst_pkg::pins_t s1;
      psram_burst_pkg::pins_t s2;
      psram_burst_pkg::pins_t s3;

      // burst engine
      psram_burst_pkg::burst_state_t st;
      logic full_sync;
      logic clocked;
      logic dir_write;
      logic [`PIN_ADDR_W-1:0] baddr;
      logic [5:0] word_cnt;
      logic [5:0] word_lim;
      logic [3:0] lat_cnt;

      // configuration
      logic [15:0] bus_config_reg;

      // read path
      logic [15:0] rbuf;
      logic rd_pend;

      // pin outputs
      logic [15:0] dq;
      logic drive;
      logic wait_o;

      // array outputs
      logic awr;
      logic ard;
      logic [`PIN_ADDR_W-1:0] aaddr;
      logic [15:0] awdata;
      logic [1:0] abe_n;

      // register read data
      logic [15:0] rdata;
   } state_t;

   state_t cur;
   state_t next_cur;

   // words per burst, zero for continuous
   function automatic logic [5:0] burst_words(input logic [2:0] code);
      unique case (code)
         `BLEN_4: burst_words = `WORDS_4;
         `BLEN_8: burst_words = `WORDS_8;
         `BLEN_16: burst_words = `WORDS_16;
         `BLEN_32: burst_words = `WORDS_32;
         default: burst_words = `WORDS_NONE;
      endcase
   endfunction

   // clock cycles of latency for a latency code
   function automatic logic [3:0] latency_cycles(input logic [2:0] code);
      latency_cycles = {1'b0, code} + `LAT_ONE;
   endfunction

   // true when the word after this address starts a new row
   function automatic logic row_last(input logic [`PIN_ADDR_W-1:0] a);
      row_last = ((a + `PIN_ADDR_W'(1)) % `PIN_ADDR_W'(ROW_WORDS)) == '0;
   endfunction

   // status word: state, mode, direction, words moved
   function automatic logic [15:0] status_word(input psram_burst_pkg::burst_state_t st, input logic fs,
         input logic wr, input logic [5:0] cnt);
      status_word = {6'h00, st, fs, wr, cnt};
   endfunction

   logic clk_rise;
   logic sync_on;
   logic lat_fixed;
   logic wait_ahead;
   logic burst_start;
   logic enables_low;
   logic enable_rose;
   psram_burst_pkg::pins_t pins_now;

   // raw pin bundle ahead of the synchroniser
   always_comb begin
      pins_now.clk = mem_clk;
      pins_now.ce_n = chip_enable_n;
      pins_now.adv_n = addr_latch_n;
      pins_now.oe_n = output_enable_n;
      pins_now.we_n = write_enable_n;
      pins_now.lb_n = lower_byte_enable_n;
      pins_now.ub_n = upper_byte_enable_n;
      pins_now.cr = config_reg_select;
      pins_now.addr = addr;
      pins_now.dq = dq_in;
   end

   // decode of configuration and synchronised pins
   always_comb begin
      // configuration fields
      sync_on = ~cur.bus_config_reg[`SYNC_MODE_BIT];
      lat_fixed = cur.bus_config_reg[`LAT_TYPE_BIT];
      wait_ahead = cur.bus_config_reg[`WAIT_TIMING_BIT];

      // link clock rise, seen between stages two and three
      clk_rise = cur.s2.clk & ~cur.s3.clk;

      // latch edge of a new burst, held off by a configuration access
      burst_start = sync_on & clk_rise & ~cur.s2.ce_n & ~cur.s2.adv_n & ~cur.s2.cr;

      // enables of an unclocked write and the first of them to rise
      enables_low = ~(cur.s3.ce_n | cur.s3.we_n | cur.s3.lb_n | cur.s3.ub_n);
      enable_rose = enables_low & (cur.s2.ce_n | cur.s2.we_n | cur.s2.lb_n | cur.s2.ub_n);
   end

   // next state of the whole block
   always_comb begin
      // hold everything unless a rule below moves it
      next_cur = cur;

      // pin pipeline: two stages synchronise, the third gives edges
      next_cur.s1 = pins_now;
      next_cur.s2 = cur.s1;
      next_cur.s3 = cur.s2;

      // array strobes last one cycle only
      next_cur.awr = 1'b0;
      next_cur.ard = 1'b0;

      // array read data is valid one cycle after the strobe
      next_cur.rd_pend = cur.ard;
      if (cur.rd_pend) begin
         next_cur.rbuf = array_rdata;
      end

      // a clock rise inside one chip enable window makes the access clocked
      if (cur.s3.ce_n) begin
         next_cur.clocked = 1'b0;
      end
      if (clk_rise && !cur.s2.ce_n) begin
         next_cur.clocked = 1'b1;
      end

      // burst engine
      if (cur.s2.ce_n || !sync_on) begin
         // chip enable high ends a burst at once and floats the data pins
         next_cur.st = psram_burst_pkg::ST_IDLE;
         next_cur.drive = 1'b0;
      end else if (burst_start) begin
         // new burst, also breaks a running one without a chip enable pulse
         next_cur.full_sync = 1'b1;
         next_cur.st = psram_burst_pkg::ST_LATENCY;
         next_cur.drive = 1'b0;

         // start address and direction come from the latch edge
         next_cur.baddr = cur.s2.addr;
         next_cur.dir_write = ~cur.s2.we_n;

         // length and latency are taken from the configuration now
         next_cur.word_cnt = '0;
         next_cur.word_lim = burst_words(cur.bus_config_reg[`BURST_LEN_HI:`BURST_LEN_LO]);
         next_cur.lat_cnt = latency_cycles(cur.bus_config_reg[`LAT_COUNT_HI:`LAT_COUNT_LO]);

         // writes ignore the latency type bit
         if (cur.s2.we_n && !lat_fixed && refresh_pending) begin
            next_cur.lat_cnt = latency_cycles(cur.bus_config_reg[`LAT_COUNT_HI:`LAT_COUNT_LO])
               + `REFRESH_EXTRA;
         end

         // reads fetch the first word during the latency
         if (cur.s2.we_n) begin
            next_cur.ard = 1'b1; // prefetch first word
            next_cur.aaddr = cur.s2.addr;
         end
      end else if (clk_rise) begin
         // latency countdown, one step per link clock rise
         unique case (cur.st)
            psram_burst_pkg::ST_IDLE: begin
               next_cur.drive = 1'b0;
            end
            psram_burst_pkg::ST_LATENCY: begin
               if (cur.lat_cnt == `LAT_ONE) begin
                  next_cur.st = psram_burst_pkg::ST_XFER;
               end else begin
                  next_cur.lat_cnt = cur.lat_cnt - `LAT_ONE;
               end
            end
            psram_burst_pkg::ST_XFER: begin
               next_cur.st = psram_burst_pkg::ST_XFER;
            end
            psram_burst_pkg::ST_ROW_END: begin
               next_cur.drive = 1'b0;
            end
         endcase

         // one word moves at each data edge
         if ((cur.st == psram_burst_pkg::ST_LATENCY && cur.lat_cnt == `LAT_ONE) ||
             cur.st == psram_burst_pkg::ST_XFER) begin
            if (cur.dir_write) begin
               // write word goes to the array with its byte enables
               next_cur.awr = 1'b1;
               next_cur.aaddr = cur.baddr;
               next_cur.awdata = cur.s2.dq;
               next_cur.abe_n = {cur.s2.ub_n, cur.s2.lb_n};
            end else begin
               // read word leaves the prefetch buffer, next one is fetched
               next_cur.dq = cur.rbuf;
               next_cur.drive = ~cur.s2.oe_n;
               next_cur.ard = 1'b1;
               next_cur.aaddr = cur.baddr + `PIN_ADDR_W'(1);
            end

            // address and count step together
            next_cur.baddr = cur.baddr + `PIN_ADDR_W'(1);
            next_cur.word_cnt = cur.word_cnt + 6'h01;

            // the burst ends at its length or parks at a row end
            if (cur.word_lim != `WORDS_NONE && cur.word_cnt + 6'h01 == cur.word_lim) begin
               next_cur.st = psram_burst_pkg::ST_IDLE;
            end else if (row_last(cur.baddr)) begin
               next_cur.st = psram_burst_pkg::ST_ROW_END;
            end else begin
               next_cur.st = psram_burst_pkg::ST_XFER;
            end
         end
      end else if (cur.st == psram_burst_pkg::ST_XFER && !cur.dir_write) begin
         // output enable gates the drive between clock edges
         next_cur.drive = ~cur.s2.oe_n;
      end

      // unclocked word write while no burst has been clocked
      // a clocked access never turns into an unclocked write on its way out
      if (sync_on && cur.st == psram_burst_pkg::ST_IDLE && !burst_start && enable_rose && !cur.clocked) begin
         next_cur.full_sync = 1'b0;
         next_cur.awr = 1'b1;
         next_cur.aaddr = cur.s3.addr;
         next_cur.awdata = cur.s3.dq;
         next_cur.abe_n = 2'b00;
      end

      // WAIT high during latency and at a row end
      unique case (next_cur.st)
         psram_burst_pkg::ST_IDLE:
            next_cur.wait_o = 1'b0;
         psram_burst_pkg::ST_LATENCY:
            next_cur.wait_o = ~(wait_ahead && next_cur.lat_cnt == `LAT_ONE);
         psram_burst_pkg::ST_XFER:
            next_cur.wait_o = 1'b0;
         psram_burst_pkg::ST_ROW_END:
            next_cur.wait_o = 1'b1;
      endcase

      // register port: configuration write
      if (reg_wr && reg_addr == `BUS_CONFIG_OFS) begin
         next_cur.bus_config_reg = reg_wdata;
      end

      // register port: read data for the next cycle
      if (reg_rd) begin
         unique case (reg_addr)
            `BUS_CONFIG_OFS: next_cur.rdata = cur.bus_config_reg;
            `STATUS_OFS: next_cur.rdata = status_word(cur.st, cur.full_sync, cur.dir_write, cur.word_cnt);
            default: next_cur.rdata = 16'h0000;
         endcase
      end
   end

   // state register
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cur <= '0;
         cur.bus_config_reg <= `BUS_CONFIG_RESET;
         cur.abe_n <= 2'b11;
         cur.st <= psram_burst_pkg::ST_IDLE;
      end else begin
         cur <= next_cur;
      end
   end

   // pin outputs straight from the state
   assign dq_out = cur.dq;
   assign dq_oe_n = ~cur.drive;
   assign wait_out = cur.wait_o;

   // array outputs straight from the state
   assign array_wr = cur.awr;
   assign array_rd = cur.ard;
   assign array_addr = cur.aaddr;
   assign array_wdata = cur.awdata;
   assign array_be_n = cur.abe_n;

   // register read data
   assign reg_rdata = cur.rdata;

endmodule
`default_nettype wire

// >>> tb_top.sv
// self-checking bench of the burst interface
`timescale 1ns/100ps
`default_nettype none
`include "psram_burst_defs.svh"
module tb_top;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic refresh_pending = 1'b0;
   logic [`REG_ADDR_W-1:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic [`PIN_DATA_W-1:0] array_rdata = 16'h0000;
   logic mem_clk, chip_enable_n, addr_latch_n, output_enable_n, write_enable_n, lower_byte_enable_n;
   logic upper_byte_enable_n, config_reg_select, dq_oe_n, wait_out, array_wr, array_rd;
   logic [1:0] array_be_n;
   logic [`PIN_DATA_W-1:0] dq_in, dq_out, array_wdata;
   logic [15:0] reg_rdata;
   logic [`PIN_ADDR_W-1:0] addr, array_addr;
   logic [40:0] wq[$];
   logic [15:0] rq[$];
   int err_count = 0;
   int tests_run = 0;
   int cyc_n = 0;
   always #25 core_clk = ~core_clk;
   psram_sync_burst_interface #(.ROW_WORDS(64)) dut_u (.core_clk, .resetn, .mem_clk, .chip_enable_n,
      .addr_latch_n, .output_enable_n, .write_enable_n, .lower_byte_enable_n, .upper_byte_enable_n,
      .config_reg_select, .addr, .dq_in, .dq_out, .dq_oe_n, .wait_out, .array_wr, .array_rd,
      .array_addr, .array_wdata, .array_be_n, .array_rdata, .refresh_pending, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
   mem_ctl_model ctl_u (.core_clk, .mem_clk, .chip_enable_n, .addr_latch_n, .output_enable_n,
      .write_enable_n, .lower_byte_enable_n, .upper_byte_enable_n, .config_reg_select, .addr,
      .dq_in, .wait_out);
   // array answers reads, records writes, bounds the run
   always @(posedge core_clk) begin
      array_rdata <= array_rd ? array_addr[15:0] : ~array_rdata;
      if (array_wr === 1'b1) wq.push_back({array_be_n, array_addr, array_wdata});
      if (dq_oe_n === 1'b0 && (rq.size() == 0 || rq[$] !== dq_out)) rq.push_back(dq_out);
      cyc_n++;
      if (cyc_n > 20000) begin
         err_count++;
         complete_run();
      end
   end
   task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      d = reg_rdata;
      @(posedge core_clk);
   endtask
   task automatic chk_val(input logic [40:0] got, input logic [40:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input int got, input int exp);
      chk_val(41'(got), 41'(exp));
   endtask
   // written words against a run of addresses
   task automatic chk_q(input logic [22:0] a, input int n, input logic [1:0] be, input logic [15:0] d);
      chk_cnt(wq.size(), n);
      for (int i = 0; i < n; i++) chk_val(wq[i], {be, a + 23'(i), d});
      wq.delete();
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // main sequence
   initial begin
      logic [15:0] r;
      int l0;
      int l1;
      int l2;
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      reg_read(`BUS_CONFIG_OFS, r);
      chk_val(41'(r), 41'(`BUS_CONFIG_RESET));
      reg_read(`STATUS_OFS, r);
      chk_val(41'(r), 41'h0);
      reg_read(4'h8, r);
      chk_val(41'(r), 41'h0);
      reg_write(`BUS_CONFIG_OFS, 16'h1001);
      reg_read(`BUS_CONFIG_OFS, r);
      chk_val(41'(r), 41'h1001);
      ctl_u.async_wr(23'h00_0012, 16'h5a5a);
      chk_q(23'h00_0012, 1, 2'h0, 16'h5a5a);
      for (int c = 1; c <= 4; c++) begin
         reg_write(`BUS_CONFIG_OFS, 16'h1000 | 16'(c));
         ctl_u.burst(23'h00_0100, 1'b1, 2'(c), 16'hc3a5, (4 << (c - 1)) + 2, 1'b0, l0);
         chk_q(23'h00_0100, 4 << (c - 1), 2'(c), 16'hc3a5);
      end
      reg_read(`STATUS_OFS, r);
      chk_val(41'(r[9:7]), 41'h1);
      for (int f = 0; f < 4; f++) begin
         reg_write(`BUS_CONFIG_OFS, f[0] ? 16'h5001 : 16'h1001);
         ctl_u.burst(23'h00_0200, f[1], 2'h0, 16'h0f0f, 1, 1'b1, l0);
         refresh_pending <= 1'b1;
         ctl_u.burst(23'h00_0210, f[1], 2'h0, 16'h0f0f, 1, 1'b0, l1);
         refresh_pending <= 1'b0;
         chk_cnt(l1 - l0, f == 0 ? 3 : 0);
         wq.delete();
      end
      reg_write(`BUS_CONFIG_OFS, 16'h5001);
      rq.delete();
      ctl_u.burst(23'h00_0300, 1'b0, 2'h0, 16'h0f0f, 1, 1'b0, l0);
      chk_cnt(rq.size(), 2);
      chk_val(41'(rq[0]), 41'h0300);
      chk_val(41'(rq[1]), 41'h0301);
      reg_write(`BUS_CONFIG_OFS, 16'h6001);
      ctl_u.burst(23'h00_0300, 1'b0, 2'h0, 16'h0f0f, 1, 1'b0, l1);
      chk_cnt(l1 - l0, 2);
      reg_write(`BUS_CONFIG_OFS, 16'h6101);
      ctl_u.burst(23'h00_0300, 1'b0, 2'h0, 16'h0f0f, 1, 1'b0, l2);
      chk_cnt(l1 - l2, 1);
      reg_write(`BUS_CONFIG_OFS, 16'h1007);
      ctl_u.burst(23'h00_003c, 1'b1, 2'h0, 16'h3c3c, 6, 1'b0, l0);
      chk_q(23'h00_003c, 4, 2'h0, 16'h3c3c);
      complete_run();
   end
endmodule
`default_nettype wire
